/* bench/test_two_register_op_decode_execute.sv */
// self-checking bench of the two-register decode/execute core
// assumes registers start at zero; r15 walks a table of load values
`timescale 1ns/1ns
module test_two_register_op_decode_execute;
	logic        clk_sys_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        instr_valid_in = 1'b0;
	logic [15:0] instr_in = 16'h0;
	logic [3:0]  dbg_sel_in = 4'h0;
	logic [2:0]  wait_r = 3'h0;
	logic        mem_ack_in, busy_out, done_out, illegal_out, addr_err_out;
	logic        mem_req_out, mem_we_out, t_flag_out;
	logic [1:0]  mem_size_out;
	logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
	logic [31:0] accum_high_out, accum_low_out, dbg_data_out;
	logic [31:0] ptr = 32'h0;
	logic        saw_req, saw_ill, saw_aerr;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          lat;

	always #4 clk_sys_in = ~clk_sys_in;

	trd_core dut_u (.clk_sys_in, .rst_n_in, .instr_valid_in, .instr_in, .mem_ack_in,
		.mem_rdata_in, .dbg_sel_in, .busy_out, .done_out, .illegal_out, .addr_err_out,
		.mem_req_out, .mem_we_out, .mem_size_out, .mem_addr_out, .mem_wdata_out,
		.t_flag_out, .accum_high_out, .accum_low_out, .dbg_data_out);

	trd_mem_model mem_u (.clk_in(clk_sys_in), .req_in(mem_req_out), .we_in(mem_we_out),
		.size_in(mem_size_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
		.wait_in(wait_r), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

	task automatic conclude();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// whole run needs several hundred cycles
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic poke(input logic [31:0] ad, input logic [31:0] d);
		for (int k = 0; k < 4; k++)
			mem_u.mem[ad[9:0] + 10'(k)] = d[8 * k +: 8];
	endtask

	function automatic logic [31:0] peek(input logic [31:0] ad);
		return {mem_u.mem[ad[9:0] + 10'h3], mem_u.mem[ad[9:0] + 10'h2],
			mem_u.mem[ad[9:0] + 10'h1], mem_u.mem[ad[9:0]]};
	endfunction

	// one instruction; lat counts cycles from take to done
	task automatic run(input logic [15:0] i);
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b1;
		instr_in <= i;
		@(posedge clk_sys_in);
		instr_valid_in <= 1'b0;
		// the take edge counts as the first state
		lat = 1;
		saw_req = 1'b0;
		#1;
		while (done_out !== 1'b1 && lat < 40) begin
			saw_req = saw_req | mem_req_out;
			@(posedge clk_sys_in);
			#1;
			lat++;
		end
		saw_req = saw_req | mem_req_out;
		saw_ill = illegal_out;
		saw_aerr = addr_err_out;
		chk({31'h0, lat < 40}, 32'h1);
	endtask

	task automatic rd(input logic [3:0] n, input logic [31:0] exp);
		@(posedge clk_sys_in);
		dbg_sel_in <= n;
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk(dbg_data_out, exp);
	endtask

	// longword post-increment load through r15
	task automatic ld(input logic [3:0] n, input logic [31:0] d);
		poke(ptr, d);
		run({4'h6, n, 4'hF, 4'h6});
		ptr += 32'h4;
	endtask

	task automatic alu(input logic [7:0] op, input logic [31:0] a, b, e, input logic et);
		ld(4'h3, a);
		ld(4'h4, b);
		run({op[7:4], 4'h3, 4'h4, op[3:0]});
		chk(32'(lat), 32'h1);
		chk({31'h0, t_flag_out}, {31'h0, et});
		rd(4'h3, e);
	endtask

	task automatic mul(input logic [7:0] op, input logic [31:0] a, b, l, hi, lo);
		ld(4'h3, a);
		ld(4'h4, b);
		run({op[7:4], 4'h3, 4'h4, op[3:0]});
		chk(32'(lat), l);
		chk(accum_high_out, hi);
		chk(accum_low_out, lo);
	endtask

	task automatic mac(input logic [7:0] op, input logic [31:0] an, am, x, y, inc, hi, lo);
		poke(an, x);
		poke(am, y);
		ld(4'h5, an);
		ld(4'h6, am);
		run({op[7:4], 4'h5, 4'h6, op[3:0]});
		chk(accum_high_out, hi);
		chk(accum_low_out, lo);
		rd(4'h5, an + inc);
		rd(4'h6, am + inc);
	endtask

	task automatic ldt(input logic [7:0] op, input logic [31:0] b0, mv, ad, d, e, inc);
		ld(4'h0, b0);
		ld(4'h6, mv);
		poke(ad, d);
		run({op[7:4], 4'h3, 4'h6, op[3:0]});
		rd(4'h3, e);
		rd(4'h6, mv + inc);
	endtask

	task automatic stt(input logic [7:0] op, input logic [31:0] b0, nv, ad, d, e, en);
		ld(4'h0, b0);
		ld(4'h3, d);
		ld(4'h5, nv);
		poke(ad, 32'h0);
		run({op[7:4], 4'h5, 4'h3, op[3:0]});
		chk(peek(ad), e);
		rd(4'h5, en);
	endtask

	task automatic bad(input logic [15:0] i, input logic il, ae);
		run(i);
		chk({31'h0, saw_ill}, {31'h0, il});
		chk({31'h0, saw_aerr}, {31'h0, ae});
		chk({31'h0, saw_req}, 32'h0);
	endtask

	initial begin
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		alu(8'h28, 32'hF0, 32'hF, 32'hF0, 1'b1);
		alu(8'h3A, 32'h5, 32'h5, 32'hFFFFFFFF, 1'b1);
		alu(8'h6A, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
		alu(8'h38, 32'h1, 32'h2, 32'hFFFFFFFF, 1'b1);
		alu(8'h6B, 32'h0, 32'h1, 32'hFFFFFFFF, 1'b1);
		alu(8'h3B, 32'h80000000, 32'h1, 32'h7FFFFFFF, 1'b1);
		alu(8'h3B, 32'h5, 32'h1, 32'h4, 1'b0);
		alu(8'h3A, 32'h5, 32'h3, 32'h2, 1'b0);
		alu(8'h6A, 32'h0, 32'h1, 32'hFFFFFFFF, 1'b1);
		alu(8'h28, 32'h3, 32'h1, 32'h3, 1'b0);
		alu(8'h2B, 32'hF0F00000, 32'hF0F, 32'hF0F00F0F, 1'b0);
		alu(8'h2A, 32'hFF00FF00, 32'hFF00FF0, 32'hF0F0F0F0, 1'b0);
		alu(8'h67, 32'h0, 32'h12345678, 32'hEDCBA987, 1'b0);
		alu(8'h6D, 32'hFFFFFFFF, 32'hFEDCBA98, 32'hBA98, 1'b0);
		alu(8'h63, 32'h0, 32'h13572468, 32'h13572468, 1'b0);
		alu(8'h68, 32'h0, 32'h11223344, 32'h11224433, 1'b0);
		alu(8'h69, 32'h0, 32'h11223344, 32'h33441122, 1'b0);
		alu(8'h2D, 32'h11223344, 32'h55667788, 32'h77881122, 1'b0);
		alu(8'h4C, 32'hF0000F0, 32'h4, 32'hF0000F00, 1'b0);
		alu(8'h4C, 32'hF0000F00, 32'h4, 32'hFF0000F0, 1'b0);
		alu(8'h4D, 32'hF0000F00, 32'h4, 32'hF0000F0, 1'b0);
		alu(8'h4D, 32'h1, 32'h1F, 32'h80000000, 1'b0);
		mul(8'h07, 32'h80000000, 32'h2, 32'h2, 32'hFFFFFFFF, 32'h0);
		mul(8'h2F, 32'hFFFFFFFE, 32'h3, 32'h1, 32'hFFFFFFFF, 32'hFFFFFFFA);
		mul(8'h2E, 32'hFFFFFFFE, 32'h3, 32'h1, 32'hFFFFFFFF, 32'h2FFFA);
		mul(8'h07, 32'h0, 32'h5, 32'h2, 32'h0, 32'h0);
		// slow far side for the memory traffic
		wait_r <= 3'h3;
		mac(8'h0F, 32'h280, 32'h290, 32'hFFFFFFFD, 32'h7, 32'h4, 32'hFFFFFFFF, 32'hFFFFFFEB);
		mac(8'h4F, 32'h284, 32'h294, 32'hFFFF, 32'h5, 32'h2, 32'hFFFFFFFF, 32'hFFFFFFE6);
		ldt(8'h60, 32'h0, 32'h301, 32'h301, 32'h85, 32'hFFFFFF85, 32'h0);
		ldt(8'h61, 32'h0, 32'h302, 32'h302, 32'h8001, 32'hFFFF8001, 32'h0);
		ldt(8'h62, 32'h0, 32'h304, 32'h304, 32'h87654321, 32'h87654321, 32'h0);
		wait_r <= 3'h0;
		ldt(8'h64, 32'h0, 32'h309, 32'h309, 32'h7F, 32'h7F, 32'h1);
		ldt(8'h65, 32'h0, 32'h30A, 32'h30A, 32'hFFFE, 32'hFFFFFFFE, 32'h2);
		ldt(8'h66, 32'h0, 32'h30C, 32'h30C, 32'h80000001, 32'h80000001, 32'h4);
		ldt(8'h0C, 32'h10, 32'h303, 32'h313, 32'h90, 32'hFFFFFF90, 32'h0);
		ldt(8'h0D, 32'h10, 32'h304, 32'h314, 32'h7FFF, 32'h7FFF, 32'h0);
		ldt(8'h0E, 32'h10, 32'h308, 32'h318, 32'hCAFE0001, 32'hCAFE0001, 32'h0);
		stt(8'h20, 32'h0, 32'h341, 32'h341, 32'h11223344, 32'h44, 32'h341);
		stt(8'h22, 32'h0, 32'h344, 32'h344, 32'h11223344, 32'h11223344, 32'h344);
		stt(8'h24, 32'h0, 32'h349, 32'h348, 32'hA1B2C3D4, 32'hD4, 32'h348);
		stt(8'h25, 32'h0, 32'h34E, 32'h34C, 32'hA1B2C3D4, 32'hC3D4, 32'h34C);
		stt(8'h26, 32'h0, 32'h354, 32'h350, 32'hA1B2C3D4, 32'hA1B2C3D4, 32'h350);
		stt(8'h04, 32'h10, 32'h350, 32'h360, 32'hA1B2C3D4, 32'hD4, 32'h350);
		stt(8'h05, 32'h10, 32'h354, 32'h364, 32'hA1B2C3D4, 32'hC3D4, 32'h354);
		stt(8'h06, 32'h10, 32'h358, 32'h368, 32'hA1B2C3D4, 32'hA1B2C3D4, 32'h358);
		ld(4'h5, 32'h227);
		ld(4'h3, 32'hA5);
		bad(16'h2536, 1'b0, 1'b1);
		rd(4'h5, 32'h227);
		bad(16'h6351, 1'b0, 1'b1);
		rd(4'h3, 32'hA5);
		bad(16'hF00F, 1'b1, 1'b0);
		rd(4'hF, ptr);
		conclude();
	end
endmodule

/* bench/trd_mem_model.sv */
// data memory partner of the core: byte array, ack after a chosen wait
// assumes the core holds a request steady until it sees ack
`timescale 1ns/1ns
module trd_mem_model (
	input  wire logic        clk_in,
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [1:0]  size_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic [2:0]  wait_in,
	output logic             ack_out,
	output logic      [31:0] rdata_out
);
	logic [7:0]  mem [0:1023];
	logic [2:0]  cnt_r = 3'h0;
	logic [31:0] last_r = 32'h0;
	logic [9:0]  a;
	assign a = addr_in[9:0];
	initial ack_out = 1'b0;
	// released bus shows the inverse, never a stale match
	assign rdata_out = ack_out ? last_r : ~last_r;
	// no second ack on the edge that takes the first
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		if (req_in && !ack_out) begin
			if (cnt_r < wait_in) begin
				cnt_r <= cnt_r + 3'h1;
			end else begin
				cnt_r <= 3'h0;
				ack_out <= 1'b1;
				last_r <= {mem[a + 10'h3], mem[a + 10'h2], mem[a + 10'h1], mem[a]};
				if (we_in) begin
					mem[a] <= wdata_in[7:0];
					if (size_in != 2'h0) begin
						mem[a + 10'h1] <= wdata_in[15:8];
					end
					if (size_in == 2'h2) begin
						mem[a + 10'h2] <= wdata_in[23:16];
						mem[a + 10'h3] <= wdata_in[31:24];
					end
				end
			end
		end
	end
endmodule

/* design/trd_core.sv */
// two-register instruction group: decode, execute, register file, flag, accumulator
// assumes fetch presents one instruction with valid while busy is low, and the
// data bus answers a held request with a one-cycle ack
//
// Behaviour
// - word zero-extend clears upper destination half
// - signed half multiply into accumulator, one state
// - unsigned half multiply into accumulator
// - long multiply two states, never stretched
// - negate with borrow, borrow to flag
// - negate, flag untouched
// - arithmetic shift, direction by printed sign
// - logical shift, direction by printed sign
// - subtract with borrow, borrow to flag
// - subtract, signed underflow to flag
// - swap bytes of lower half
// - swap the two halves
// - and-test sets flag when result zero
// - extract middle 32 bits of pair
// - long accumulate, both addresses plus four
// - half accumulate, both addresses plus two
// - post-increment load advances source by size
// - pre-decrement store lowers address first
// - indirect load sign-extends byte and word
// - indexed load at base plus source
// - indexed store at base plus destination
// - or, xor, not in one state
// - accumulator is high and low word pair
`timescale 1ns/1ns
module trd_core (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        instr_valid_in,
	input  wire logic [15:0] instr_in,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	input  wire logic [3:0]  dbg_sel_in,
	output logic             busy_out,
	output logic             done_out,
	output logic             illegal_out,
	output logic             addr_err_out,
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic      [1:0]  mem_size_out,
	output logic      [31:0] mem_addr_out,
	output logic      [31:0] mem_wdata_out,
	output logic             t_flag_out,
	output logic      [31:0] accum_high_out,
	output logic      [31:0] accum_low_out,
	output logic      [31:0] dbg_data_out
);
	logic [31:0]         regs_r [trd_pkg::NREGS];
	logic                t_r;
	logic [31:0]         acc_hi_r;
	logic [31:0]         acc_lo_r;
	logic [31:0]         op1_r;
	trd_pkg::trd_state_t state_r;
	trd_pkg::trd_op_t    op;
	trd_pkg::trd_op_t    pend_op_r;
	logic [3:0]          pend_dst_r;
	logic [3:0]          pend_src_r;
	logic [31:0]         pend_addr2_r;
	logic [3:0]          maj;
	logic [3:0]          mn;
	logic [3:0]          n_idx;
	logic [3:0]          m_idx;
	logic [31:0]         rn_val;
	logic [31:0]         rm_val;
	logic                acc;
	logic                ack_ok;
	logic                d_wr;
	logic [31:0]         d_res;
	logic                d_twr;
	logic                d_t;
	logic                d_mem;
	logic                d_we;
	logic [31:0]         d_addr;
	logic [31:0]         d_addr2;
	logic [31:0]         d_wdata;
	logic [31:0]         d_bytes;
	logic                mis;
	logic [32:0]         wide;
	logic [31:0]         zx_half;
	logic [31:0]         ld_ext;
	logic [63:0]         mac_prod;
	logic [63:0]         mull_prod;
	logic [31:0]         signed_half_multiply_prod;
	logic [31:0]         unsigned_half_multiply_prod;
	logic [31:0]         cnt_ext;
	logic [1:0]          sz;

	assign maj    = instr_in[trd_pkg::MAJ_LSB +: trd_pkg::NIB];
	assign n_idx  = instr_in[trd_pkg::DST_LSB +: trd_pkg::RIDX];
	assign m_idx  = instr_in[trd_pkg::SRC_LSB +: trd_pkg::RIDX];
	assign mn     = instr_in[trd_pkg::NIB-1:0];
	assign sz     = mn[1:0];
	assign rn_val = regs_r[n_idx];
	assign rm_val = regs_r[m_idx];
	assign acc    = instr_valid_in && !busy_out;
	assign ack_ok = mem_req_out && mem_ack_in;

	assign t_flag_out     = t_r;
	assign accum_high_out = acc_hi_r;
	assign accum_low_out  = acc_lo_r;

	trd_extend u_zx (
		.data_in  (rm_val),
		.size_in  (trd_pkg::SZ_W),
		.sign_in  (1'h0),
		.data_out (zx_half)
	);

	// loads are always sign-extended; longwords pass through
	trd_extend u_ld (
		.data_in  (mem_rdata_in),
		.size_in  (mem_size_out),
		.sign_in  (1'h1),
		.data_out (ld_ext)
	);

	always_comb begin
		op = trd_pkg::OP_ILL;
		unique case (maj)
			trd_pkg::MAJ_0: begin
				if (mn == trd_pkg::MN_LONG_MULTIPLY) op = trd_pkg::OP_MULL;
				else if (mn == trd_pkg::MN_MAC) op = trd_pkg::OP_ACCUM_LOW_WORD;
				else if (sz != trd_pkg::SZ_BAD && mn[3:2] == trd_pkg::GRP_B) op = trd_pkg::OP_STX;
				else if (sz != trd_pkg::SZ_BAD && mn[3:2] == trd_pkg::GRP_D) op = trd_pkg::OP_LDX;
			end
			trd_pkg::MAJ_2: begin
				if (mn == trd_pkg::MN_SIGNED_HALF_MULTIPLY) op = trd_pkg::OP_SIGNED_HALF_MULTIPLY;
				else if (mn == trd_pkg::MN_UNSIGNED_HALF_MULTIPLY) op = trd_pkg::OP_UNSIGNED_HALF_MULTIPLY;
				else if (mn == trd_pkg::MN_OR) op = trd_pkg::OP_OR;
				else if (mn == trd_pkg::MN_TST) op = trd_pkg::OP_TST;
				else if (mn == trd_pkg::MN_XOR) op = trd_pkg::OP_XOR;
				else if (mn == trd_pkg::MN_MIDDLE_EXTRACT) op = trd_pkg::OP_MIDDLE_EXTRACT;
				else if (sz != trd_pkg::SZ_BAD && mn[3:2] == trd_pkg::GRP_A) op = trd_pkg::OP_ST;
				else if (sz != trd_pkg::SZ_BAD && mn[3:2] == trd_pkg::GRP_B) op = trd_pkg::OP_STPD;
			end
			trd_pkg::MAJ_3: begin
				if (mn == trd_pkg::MN_SUB) op = trd_pkg::OP_SUB;
				else if (mn == trd_pkg::MN_SUBTRACT_WITH_BORROW) op = trd_pkg::OP_SUBTRACT_WITH_BORROW;
				else if (mn == trd_pkg::MN_SUBTRACT_CHECK_UNDERFLOW) op = trd_pkg::OP_SUBTRACT_CHECK_UNDERFLOW;
			end
			trd_pkg::MAJ_4: begin
				if (mn == trd_pkg::MN_DYNAMIC_ARITH_SHIFT) op = trd_pkg::OP_DYNAMIC_ARITH_SHIFT;
				else if (mn == trd_pkg::MN_DYNAMIC_LOGIC_SHIFT) op = trd_pkg::OP_DYNAMIC_LOGIC_SHIFT;
				else if (mn == trd_pkg::MN_MAC) op = trd_pkg::OP_MACW;
			end
			trd_pkg::MAJ_6: begin
				if (mn == trd_pkg::MN_ZERO_EXTEND_HALF) op = trd_pkg::OP_EXTU;
				else if (mn == trd_pkg::MN_MOV) op = trd_pkg::OP_MOV;
				else if (mn == trd_pkg::MN_NEG) op = trd_pkg::OP_NEG;
				else if (mn == trd_pkg::MN_NEGATE_WITH_BORROW) op = trd_pkg::OP_NEGATE_WITH_BORROW;
				else if (mn == trd_pkg::MN_NOT) op = trd_pkg::OP_NOT;
				else if (mn == trd_pkg::MN_SWAP_B) op = trd_pkg::OP_SWAPB;
				else if (mn == trd_pkg::MN_SWAP_W) op = trd_pkg::OP_SWAPW;
				else if (sz != trd_pkg::SZ_BAD && mn[3:2] == trd_pkg::GRP_A) op = trd_pkg::OP_LD;
				else if (sz != trd_pkg::SZ_BAD && mn[3:2] == trd_pkg::GRP_B) op = trd_pkg::OP_LDPI;
			end
			default: op = trd_pkg::OP_ILL;
		endcase
	end

	assign signed_half_multiply_prod = 32'($signed(rn_val[15:0]) * $signed(rm_val[15:0]));
	assign unsigned_half_multiply_prod = 32'(rn_val[15:0] * rm_val[15:0]);
	assign mull_prod = 64'($signed(rn_val) * $signed(rm_val));
	assign mac_prod  = 64'($signed(op1_r) * $signed(ld_ext));
	assign cnt_ext   = {27'h0, rm_val[trd_pkg::SHAMT_W-1:0]};

	always_comb begin
		d_bytes = (sz == trd_pkg::SZ_B) ? trd_pkg::BYTES_B :
			(sz == trd_pkg::SZ_W) ? trd_pkg::BYTES_W : trd_pkg::BYTES_L;
		if (op == trd_pkg::OP_ACCUM_LOW_WORD) d_bytes = trd_pkg::BYTES_L;
		if (op == trd_pkg::OP_MACW) d_bytes = trd_pkg::BYTES_W;
		d_wr    = 1'h1;
		d_res   = trd_pkg::ZERO32;
		d_twr   = 1'h0;
		d_t     = t_r;
		d_mem   = 1'h0;
		d_we    = 1'h0;
		d_addr  = rn_val;
		d_addr2 = (n_idx == m_idx) ? rm_val + d_bytes : rm_val;
		d_wdata = rm_val;
		wide    = 33'h0;
		unique case (op)
			trd_pkg::OP_EXTU:  d_res = zx_half;
			trd_pkg::OP_MOV:   d_res = rm_val;
			trd_pkg::OP_NEG:   d_res = trd_pkg::ZERO32 - rm_val;
			trd_pkg::OP_NEGATE_WITH_BORROW: begin
				wide  = 33'h0 - {1'h0, rm_val} - {32'h0, t_r};
				d_res = wide[31:0];
				d_twr = 1'h1;
				d_t   = wide[32];
			end
			trd_pkg::OP_NOT:   d_res = ~rm_val;
			trd_pkg::OP_OR:    d_res = rn_val | rm_val;
			trd_pkg::OP_XOR:   d_res = rn_val ^ rm_val;
			// direction follows the printed test on the destination sign
			trd_pkg::OP_DYNAMIC_ARITH_SHIFT:  d_res = rn_val[31] ? 32'($signed(rn_val) >>> cnt_ext) :
				(rn_val << cnt_ext);
			trd_pkg::OP_DYNAMIC_LOGIC_SHIFT:  d_res = rn_val[31] ? (rn_val >> cnt_ext) :
				(rn_val << cnt_ext);
			trd_pkg::OP_SUB:   d_res = rn_val - rm_val;
			trd_pkg::OP_SUBTRACT_WITH_BORROW: begin
				wide  = {1'h0, rn_val} - {1'h0, rm_val} - {32'h0, t_r};
				d_res = wide[31:0];
				d_twr = 1'h1;
				d_t   = wide[32];
			end
			trd_pkg::OP_SUBTRACT_CHECK_UNDERFLOW: begin
				d_res = rn_val - rm_val;
				d_twr = 1'h1;
				d_t   = (rn_val[31] != rm_val[31]) && (d_res[31] != rn_val[31]);
			end
			trd_pkg::OP_SWAPB: d_res = {rm_val[31:16], rm_val[7:0], rm_val[15:8]};
			trd_pkg::OP_SWAPW: d_res = {rm_val[15:0], rm_val[31:16]};
			trd_pkg::OP_TST: begin
				d_wr  = 1'h0;
				d_twr = 1'h1;
				d_t   = ((rn_val & rm_val) == trd_pkg::ZERO32);
			end
			trd_pkg::OP_MIDDLE_EXTRACT: d_res = {rm_val[15:0], rn_val[31:16]};
			trd_pkg::OP_ACCUM_LOW_WORD, trd_pkg::OP_MACW: begin
				d_wr  = 1'h0;
				d_mem = 1'h1;
			end
			trd_pkg::OP_ST: begin
				d_wr  = 1'h0;
				d_mem = 1'h1;
				d_we  = 1'h1;
			end
			trd_pkg::OP_STPD: begin
				d_wr   = 1'h0;
				d_mem  = 1'h1;
				d_we   = 1'h1;
				d_addr = rn_val - d_bytes;
			end
			trd_pkg::OP_STX: begin
				d_wr   = 1'h0;
				d_mem  = 1'h1;
				d_we   = 1'h1;
				d_addr = regs_r[trd_pkg::IDX_BASE] + rn_val;
			end
			trd_pkg::OP_LD, trd_pkg::OP_LDPI: begin
				d_wr   = 1'h0;
				d_mem  = 1'h1;
				d_addr = rm_val;
			end
			trd_pkg::OP_LDX: begin
				d_wr   = 1'h0;
				d_mem  = 1'h1;
				d_addr = regs_r[trd_pkg::IDX_BASE] + rm_val;
			end
			default: d_wr = 1'h0;
		endcase
	end

	// a misaligned second accumulate operand aborts before either read
	always_comb begin
		mis = 1'h0;
		if (d_bytes == trd_pkg::BYTES_W) mis = d_addr[0] ||
			((op == trd_pkg::OP_MACW) && d_addr2[0]);
		if (d_bytes == trd_pkg::BYTES_L) mis = (d_addr[1:0] != 2'h0) ||
			((op == trd_pkg::OP_ACCUM_LOW_WORD) && (d_addr2[1:0] != 2'h0));
		mis = mis && d_mem;
	end

	localparam logic [31:0] ZERO = trd_pkg::ZERO32;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r       <= trd_pkg::ST_IDLE;
			busy_out      <= 1'h0;
			done_out      <= 1'h0;
			illegal_out   <= 1'h0;
			addr_err_out  <= 1'h0;
			mem_req_out   <= 1'h0;
			mem_we_out    <= 1'h0;
			mem_size_out  <= trd_pkg::SZ_B;
			mem_addr_out  <= ZERO;
			mem_wdata_out <= ZERO;
			pend_op_r     <= trd_pkg::OP_ILL;
			pend_dst_r    <= 4'h0;
			pend_src_r    <= 4'h0;
			pend_addr2_r  <= ZERO;
		end else begin
			done_out     <= 1'h0;
			illegal_out  <= 1'h0;
			addr_err_out <= 1'h0;
			unique case (state_r)
				trd_pkg::ST_IDLE: begin
					if (acc) begin
						if (op == trd_pkg::OP_ILL) begin
							illegal_out <= 1'h1;
							done_out    <= 1'h1;
						end else if (mis) begin
							addr_err_out <= 1'h1;
							done_out     <= 1'h1;
						end else if (d_mem) begin
							mem_req_out   <= 1'h1;
							mem_we_out    <= d_we;
							mem_addr_out  <= d_addr;
							mem_wdata_out <= d_wdata;
							mem_size_out  <= (d_bytes == trd_pkg::BYTES_L) ? trd_pkg::SZ_L :
								(d_bytes == trd_pkg::BYTES_W) ? trd_pkg::SZ_W : trd_pkg::SZ_B;
							pend_op_r     <= op;
							pend_dst_r    <= n_idx;
							pend_src_r    <= m_idx;
							pend_addr2_r  <= d_addr2;
							busy_out      <= 1'h1;
							state_r       <= trd_pkg::ST_MEM;
						end else if (op == trd_pkg::OP_MULL) begin
							busy_out <= 1'h1;
							state_r  <= trd_pkg::ST_MUL;
						end else begin
							done_out <= 1'h1;
						end
					end
				end
				trd_pkg::ST_MEM: begin
					if (mem_ack_in) begin
						if (pend_op_r == trd_pkg::OP_ACCUM_LOW_WORD || pend_op_r == trd_pkg::OP_MACW) begin
							mem_addr_out <= pend_addr2_r;
							state_r      <= trd_pkg::ST_MAC2;
						end else begin
							mem_req_out <= 1'h0;
							mem_we_out  <= 1'h0;
							busy_out    <= 1'h0;
							done_out    <= 1'h1;
							state_r     <= trd_pkg::ST_IDLE;
						end
					end
				end
				trd_pkg::ST_MAC2: begin
					if (mem_ack_in) begin
						mem_req_out <= 1'h0;
						busy_out    <= 1'h0;
						done_out    <= 1'h1;
						state_r     <= trd_pkg::ST_IDLE;
					end
				end
				trd_pkg::ST_MUL: begin
					busy_out <= 1'h0;
					done_out <= 1'h1;
					state_r  <= trd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// later assignments win: a load into its own address register keeps the data
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < trd_pkg::NREGS; i++) regs_r[i] <= ZERO;
		end else begin
			if (acc && d_wr) regs_r[n_idx] <= d_res;
			if (acc && op == trd_pkg::OP_STPD && !mis) regs_r[n_idx] <= d_addr;
			if (ack_ok) begin
				if (pend_op_r == trd_pkg::OP_ACCUM_LOW_WORD || pend_op_r == trd_pkg::OP_MACW) begin
					if (state_r == trd_pkg::ST_MEM)
						regs_r[pend_dst_r] <= regs_r[pend_dst_r] + (32'h1 << mem_size_out);
					else
						regs_r[pend_src_r] <= regs_r[pend_src_r] + (32'h1 << mem_size_out);
				end else if (!mem_we_out) begin
					if (pend_op_r == trd_pkg::OP_LDPI)
						regs_r[pend_src_r] <= regs_r[pend_src_r] + (32'h1 << mem_size_out);
					regs_r[pend_dst_r] <= ld_ext;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) t_r <= 1'h0;
		else if (acc && d_twr) t_r <= d_t;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_hi_r <= ZERO;
			acc_lo_r <= ZERO;
			op1_r    <= ZERO;
		end else begin
			if (acc && op == trd_pkg::OP_SIGNED_HALF_MULTIPLY) acc_lo_r <= signed_half_multiply_prod;
			if (acc && op == trd_pkg::OP_UNSIGNED_HALF_MULTIPLY) acc_lo_r <= unsigned_half_multiply_prod;
			if (acc && op == trd_pkg::OP_MULL) {acc_hi_r, acc_lo_r} <= mull_prod;
			if (ack_ok && state_r == trd_pkg::ST_MEM) op1_r <= ld_ext;
			if (ack_ok && state_r == trd_pkg::ST_MAC2)
				{acc_hi_r, acc_lo_r} <= {acc_hi_r, acc_lo_r} + mac_prod;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) dbg_data_out <= ZERO;
		else dbg_data_out <= regs_r[dbg_sel_in];
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	property p_zext;
		acc && op == trd_pkg::OP_EXTU |=>
			regs_r[$past(n_idx)] == ($past(rm_val) & trd_pkg::HALF_MASK);
	endproperty
	a_zext: assert property (p_zext) else $error("zero extend wrong");

	property p_neg;
		acc && op == trd_pkg::OP_NEG |=>
			regs_r[$past(n_idx)] == -$past(rm_val) && t_r == $past(t_r);
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong");

	property p_tst;
		acc && op == trd_pkg::OP_TST |=>
			t_r == (($past(rn_val) & $past(rm_val)) == ZERO) &&
			regs_r[$past(n_idx)] == $past(rn_val);
	endproperty
	a_tst: assert property (p_tst) else $error("and test wrong");

	property p_swapw;
		acc && op == trd_pkg::OP_SWAPW |=>
			regs_r[$past(n_idx)] == {$past(rm_val[15:0]), $past(rm_val[31:16])};
	endproperty
	a_swapw: assert property (p_swapw) else $error("half swap wrong");

	property p_signed_half_multiply;
		acc && op == trd_pkg::OP_SIGNED_HALF_MULTIPLY |=> acc_lo_r == $past(signed_half_multiply_prod) && !busy_out && done_out;
	endproperty
	a_signed_half_multiply: assert property (p_signed_half_multiply) else $error("signed multiply wrong");

	sequence s_mull_body;
		busy_out && !done_out ##1 !busy_out && done_out;
	endsequence
	property p_mull;
		acc && op == trd_pkg::OP_MULL |=> s_mull_body;
	endproperty
	a_mull: assert property (p_mull) else $error("long multiply timing wrong");

	property p_mis;
		acc && d_mem && d_bytes != trd_pkg::BYTES_B && d_addr[0] |=>
			addr_err_out && done_out && !mem_req_out;
	endproperty
	a_mis: assert property (p_mis) else $error("misaligned access not refused");

	property p_predec;
		acc && op == trd_pkg::OP_STPD && !mis |=> mem_req_out && mem_we_out &&
			mem_addr_out == $past(rn_val) - $past(d_bytes) &&
			regs_r[$past(n_idx)] == mem_addr_out;
	endproperty
	a_predec: assert property (p_predec) else $error("pre-decrement wrong");

	sequence s_mac_second;
		mem_req_out && !mem_we_out && state_r == trd_pkg::ST_MAC2;
	endsequence
	property p_mac_two_reads;
		state_r == trd_pkg::ST_MEM && ack_ok &&
			(pend_op_r == trd_pkg::OP_ACCUM_LOW_WORD || pend_op_r == trd_pkg::OP_MACW) |=>
			s_mac_second and mem_addr_out == $past(pend_addr2_r);
	endproperty
	a_mac_two_reads: assert property (p_mac_two_reads) else $error("second read missing");
endmodule

/* design/trd_extend.sv */
// byte/word extender, sign or zero fill; longword passes unchanged
// purely combinational, sized by the package access-size codes
`timescale 1ns/1ns
module trd_extend (
	input  wire logic [31:0] data_in,
	input  wire logic [1:0]  size_in,
	input  wire logic        sign_in,
	output logic      [31:0] data_out
);
	always_comb begin
		unique case (size_in)
			trd_pkg::SZ_B: data_out = {{24{sign_in & data_in[7]}}, data_in[7:0]};
			trd_pkg::SZ_W: data_out = {{16{sign_in & data_in[15]}}, data_in[15:0]};
			default:       data_out = data_in;
		endcase
	end
endmodule

/* design/trd_pkg.sv */
// opcode fields, sizes, states and constants of the two-register decode/execute block
// assumes a single core clock; no part of this package is software visible
package trd_pkg;
	localparam int XLEN    = 32;
	localparam int HALF    = 16;
	localparam int RIDX    = 4;
	localparam int NREGS   = 16;
	localparam int NIB     = 4;
	localparam int MAJ_LSB = 12;
	localparam int DST_LSB = 8;
	localparam int SRC_LSB = 4;
	localparam int SHAMT_W = 5;

	localparam logic [3:0] MAJ_0 = 4'h0;
	localparam logic [3:0] MAJ_2 = 4'h2;
	localparam logic [3:0] MAJ_3 = 4'h3;
	localparam logic [3:0] MAJ_4 = 4'h4;
	localparam logic [3:0] MAJ_6 = 4'h6;

	// minor nibbles
	localparam logic [3:0] MN_LONG_MULTIPLY  = 4'h7;
	localparam logic [3:0] MN_MAC    = 4'hF;
	localparam logic [3:0] MN_SIGNED_HALF_MULTIPLY   = 4'hF;
	localparam logic [3:0] MN_UNSIGNED_HALF_MULTIPLY   = 4'hE;
	localparam logic [3:0] MN_OR     = 4'hB;
	localparam logic [3:0] MN_TST    = 4'h8;
	localparam logic [3:0] MN_XOR    = 4'hA;
	localparam logic [3:0] MN_MIDDLE_EXTRACT  = 4'hD;
	localparam logic [3:0] MN_SUB    = 4'h8;
	localparam logic [3:0] MN_SUBTRACT_WITH_BORROW   = 4'hA;
	localparam logic [3:0] MN_SUBTRACT_CHECK_UNDERFLOW   = 4'hB;
	localparam logic [3:0] MN_DYNAMIC_ARITH_SHIFT   = 4'hC;
	localparam logic [3:0] MN_DYNAMIC_LOGIC_SHIFT   = 4'hD;
	localparam logic [3:0] MN_ZERO_EXTEND_HALF = 4'hD;
	localparam logic [3:0] MN_MOV    = 4'h3;
	localparam logic [3:0] MN_NEG    = 4'hB;
	localparam logic [3:0] MN_NEGATE_WITH_BORROW   = 4'hA;
	localparam logic [3:0] MN_NOT    = 4'h7;
	localparam logic [3:0] MN_SWAP_B = 4'h8;
	localparam logic [3:0] MN_SWAP_W = 4'h9;

	// memory groups: minor[3:2], access size in minor[1:0]
	localparam logic [1:0] GRP_A = 2'h0;
	localparam logic [1:0] GRP_B = 2'h1;
	localparam logic [1:0] GRP_D = 2'h3;

	localparam logic [1:0] SZ_B   = 2'h0;
	localparam logic [1:0] SZ_W   = 2'h1;
	localparam logic [1:0] SZ_L   = 2'h2;
	localparam logic [1:0] SZ_BAD = 2'h3;

	localparam logic [31:0] BYTES_B   = 32'h1;
	localparam logic [31:0] BYTES_W   = 32'h2;
	localparam logic [31:0] BYTES_L   = 32'h4;
	localparam logic [31:0] HALF_MASK = 32'h0000FFFF;
	localparam logic [31:0] ZERO32    = 32'h0;
	localparam logic [3:0]  IDX_BASE  = 4'h0;

	typedef enum {ST_IDLE, ST_MEM, ST_MAC2, ST_MUL} trd_state_t;

	typedef enum {OP_ILL, OP_EXTU, OP_MOV, OP_MULL, OP_SIGNED_HALF_MULTIPLY, OP_UNSIGNED_HALF_MULTIPLY, OP_NEG, OP_NEGATE_WITH_BORROW,
		OP_NOT, OP_OR, OP_DYNAMIC_ARITH_SHIFT, OP_DYNAMIC_LOGIC_SHIFT, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CHECK_UNDERFLOW, OP_SWAPB, OP_SWAPW,
		OP_TST, OP_XOR, OP_MIDDLE_EXTRACT, OP_ACCUM_LOW_WORD, OP_MACW, OP_ST, OP_STPD, OP_STX, OP_LD,
		OP_LDPI, OP_LDX} trd_op_t;
endpackage
